// File: verilog/cad_pkg.sv
// shared constants, types and helpers for the cyclic assembly command link
package cad_pkg;
    localparam int REQ_LEN = 344;
    localparam int RSP_LEN = 444;
    typedef logic [8:0] cad_idx_type;
    localparam cad_idx_type REQ_LAST = 9'(REQ_LEN - 1);
    localparam cad_idx_type RSP_LAST = 9'(RSP_LEN - 1);

    // request frame layout, all word fields start on a 4-byte boundary
    localparam cad_idx_type OFS_KEY = 9'h000;
    localparam cad_idx_type OFS_NCHAR = 9'h004;
    localparam cad_idx_type OFS_CHAR = 9'h008;
    localparam cad_idx_type OFS_INT0 = 9'h108;
    localparam cad_idx_type OFS_INT1 = 9'h10c;
    localparam cad_idx_type OFS_INT2 = 9'h110;
    // response frame layout
    localparam cad_idx_type OFS_RSP_KEY = 9'h000;
    localparam cad_idx_type OFS_BOOL = 9'h05c;
    localparam cad_idx_type OFS_TEXT = 9'h074;
    localparam cad_idx_type OFS_INTRES = 9'h0f4;

    localparam logic [15:0] CMD_TRIGGER = 16'h0001;
    localparam logic [15:0] CMD_JOB = 16'h0002;
    localparam logic [15:0] CMD_REF_PERM = 16'h0005;
    localparam logic [15:0] CMD_REF_TEMP = 16'h0006;
    localparam logic [15:0] NINT_JOB = 16'h0001;
    localparam logic [15:0] NINT_REF = 16'h0003;
    localparam logic [31:0] PARAM_REF_STR = 32'h00000065;
    localparam logic [31:0] PTYPE_STR = 32'h0000000a;
    localparam logic [15:0] KEY_RST = 16'h0000;

    // controller register map (byte addresses)
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_CNT = 8'h04;
    localparam logic [7:0] REG_ARG0 = 8'h08;
    localparam logic [7:0] REG_ARG1 = 8'h0c;
    localparam logic [7:0] REG_ARG2 = 8'h10;
    localparam logic [7:0] REG_TEXT = 8'h14;
    localparam logic [7:0] REG_STAT = 8'h18;
    localparam logic [7:0] REG_BOOL = 8'h1c;
    localparam logic [7:0] REG_INTRES = 8'h20;
    localparam logic [7:0] REG_TEXTRES = 8'h24;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef enum logic [1:0] {D_RECV = 2'b00, D_EVAL = 2'b01, D_RESP = 2'b11} cad_dev_state_type;
    typedef enum logic [1:0] {H_IDLE = 2'b00, H_SEND = 2'b01, H_WAIT = 2'b11} cad_ctl_state_type;

    function automatic logic word_hit(input cad_idx_type idx, input cad_idx_type ofs);
        return idx[8:2] == ofs[8:2];
    endfunction

    // little-endian byte of a word, as the binary telegram lays it out
    function automatic logic [7:0] lane_byte(input logic [31:0] w, input logic [1:0] l);
        logic [31:0] s;
        s = w >> {l, 3'b000};
        return s[7:0];
    endfunction
endpackage

// File: verilog/cad_link_if.sv
// byte-serial request and response frames between controller and sensor
`timescale 1ns/1ps
`default_nettype none
interface cad_link_if;
    logic req_valid;
    logic [7:0] req_data;
    logic req_last;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_last;
    logic sensor_ready;
    modport dev (
        input req_valid, req_data, req_last,
        output rsp_valid, rsp_data, rsp_last, sensor_ready
    );
    modport ctl (
        output req_valid, req_data, req_last,
        input rsp_valid, rsp_data, rsp_last, sensor_ready
    );
endinterface
`default_nettype wire

// File: verilog/cad_dev.sv
// sensor end: decodes request frames, launches commands, builds response frames
// Function
// - request frame is exactly 344 bytes
// - response frame is exactly 444 bytes
// - bytes 0-1 are key, change means new
// - only a key change launches a command
// - command code read from bytes 2-3
// - code 0x01 triggers one image
// - code 0x02 changes job, number at 264
// - code 0x05 stores reference string permanently
// - code 0x06 sets reference string temporarily
// - controller triggers only while ready
// - sensor is ready before connection is made
// - results at bytes 92, 116, 244
// - results use little-endian binary encoding
`timescale 1ns/1ps
`default_nettype none
module cad_dev (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    cad_link_if.dev link,
    input wire logic sensor_ready,
    input wire logic [7:0] bool_result,
    input wire logic [31:0] text_result,
    input wire logic [31:0] int_result,
    output logic trig_pulse,
    output logic job_pulse,
    output logic [31:0] job_number,
    output logic ref_perm_pulse,
    output logic ref_temp_pulse,
    output logic [15:0] ref_len,
    output logic [31:0] ref_text,
    output logic [31:0] ref_detector,
    output logic [31:0] ref_param,
    output logic [31:0] ref_type,
    output logic len_error
);
    import cad_pkg::*;

    cad_dev_state_type state_ff;
    cad_dev_state_type nxt_state;
    cad_idx_type rx_idx_ff;
    cad_idx_type nxt_rx_idx;
    logic rx_bad_ff;
    logic nxt_rx_bad;
    logic [31:0] hdr0_ff;
    logic [31:0] hdr1_ff;
    logic [31:0] text_ff;
    logic [31:0] int0_ff;
    logic [31:0] int1_ff;
    logic [31:0] int2_ff;
    logic [15:0] key_ff;
    cad_idx_type tx_idx_ff;
    logic [7:0] res_bool_ff;
    logic [31:0] res_text_ff;
    logic [31:0] res_int_ff;
    logic rsp_valid_ff;
    logic [7:0] rsp_data_ff;
    logic rsp_last_ff;
    logic ready_ff;
    logic trig_ff;
    logic job_ff;
    logic perm_ff;
    logic temp_ff;
    logic len_err_ff;
    logic [31:0] job_num_ff;
    logic [15:0] ref_len_ff;
    logic [31:0] ref_text_ff;
    logic [31:0] ref_det_ff;
    logic [31:0] ref_par_ff;
    logic [31:0] ref_typ_ff;

    wire [1:0] rx_lane = rx_idx_ff[1:0];
    wire rx_take = (state_ff == D_RECV) && link.req_valid;
    wire rx_at_last = (rx_idx_ff == REQ_LAST);
    wire frame_ok = rx_take && link.req_last && !rx_bad_ff && rx_at_last;
    wire frame_bad = rx_take && link.req_last && !frame_ok;
    wire [15:0] key_new = hdr0_ff[15:0];
    wire [15:0] code = hdr0_ff[31:16];
    wire [15:0] nint = hdr1_ff[31:16];
    wire [15:0] nchar = hdr1_ff[15:0];
    wire key_changed = (state_ff == D_EVAL) && (key_new != key_ff);
    wire trig_go = key_changed && (code == CMD_TRIGGER);
    // a job change without its one integer argument is dropped
    wire job_go = key_changed && (code == CMD_JOB) && (nint >= NINT_JOB);
    wire perm_go = key_changed && (code == CMD_REF_PERM) && (nint >= NINT_REF);
    wire temp_go = key_changed && (code == CMD_REF_TEMP) && (nint >= NINT_REF);
    wire ref_go = perm_go || temp_go;
    wire [1:0] tx_lane = tx_idx_ff[1:0];
    wire tx_at_last = (tx_idx_ff == RSP_LAST);

    // response byte, zero outside the key and result fields
    wire [7:0] tx_byte =
        word_hit(tx_idx_ff, OFS_RSP_KEY) ? lane_byte({24'h000000, key_ff[7:0]}, tx_lane) :
        word_hit(tx_idx_ff, OFS_BOOL) ? lane_byte({24'h000000, res_bool_ff}, tx_lane) :
        word_hit(tx_idx_ff, OFS_TEXT) ? lane_byte(res_text_ff, tx_lane) :
        word_hit(tx_idx_ff, OFS_INTRES) ? lane_byte(res_int_ff, tx_lane) :
        8'h00;

    // an overlong frame is marked bad and waits for its last byte
    assign nxt_rx_bad = !rx_take ? rx_bad_ff :
                        link.req_last ? 1'b0 : (rx_bad_ff || rx_at_last);
    assign nxt_rx_idx = !rx_take ? rx_idx_ff :
                        (link.req_last || rx_at_last) ? 9'h000 : 9'(rx_idx_ff + 9'h001);

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            D_RECV: if (frame_ok) nxt_state = D_EVAL;
            D_EVAL: nxt_state = D_RESP;
            D_RESP: if (tx_at_last) nxt_state = D_RECV;
            default: nxt_state = D_RECV;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= D_RECV;
            rx_idx_ff <= 9'h000;
            rx_bad_ff <= 1'b0;
            ready_ff <= 1'b0;
            len_err_ff <= 1'b0;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
            rx_idx_ff <= nxt_rx_idx;
            rx_bad_ff <= nxt_rx_bad;
            ready_ff <= sensor_ready;
            len_err_ff <= frame_bad;
        end
    end

    // shadows fill from any frame; only a whole frame is acted on
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hdr0_ff <= 32'h00000000;
            hdr1_ff <= 32'h00000000;
            text_ff <= 32'h00000000;
            int0_ff <= 32'h00000000;
            int1_ff <= 32'h00000000;
            int2_ff <= 32'h00000000;
        end
        else if (ce && rx_take)
        begin
            if (word_hit(rx_idx_ff, OFS_KEY)) hdr0_ff[{rx_lane, 3'b000} +: 8] <= link.req_data;
            if (word_hit(rx_idx_ff, OFS_NCHAR)) hdr1_ff[{rx_lane, 3'b000} +: 8] <= link.req_data;
            if (word_hit(rx_idx_ff, OFS_CHAR)) text_ff[{rx_lane, 3'b000} +: 8] <= link.req_data;
            if (word_hit(rx_idx_ff, OFS_INT0)) int0_ff[{rx_lane, 3'b000} +: 8] <= link.req_data;
            if (word_hit(rx_idx_ff, OFS_INT1)) int1_ff[{rx_lane, 3'b000} +: 8] <= link.req_data;
            if (word_hit(rx_idx_ff, OFS_INT2)) int2_ff[{rx_lane, 3'b000} +: 8] <= link.req_data;
        end
    end

    // key is remembered even for unknown codes, so they never re-fire
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            key_ff <= KEY_RST;
            trig_ff <= 1'b0;
            job_ff <= 1'b0;
            perm_ff <= 1'b0;
            temp_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (key_changed) key_ff <= key_new;
            trig_ff <= trig_go;
            job_ff <= job_go;
            perm_ff <= perm_go;
            temp_ff <= temp_go;
        end
    end

    // only the first four characters of the reference string are kept
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            job_num_ff <= 32'h00000000;
            ref_len_ff <= 16'h0000;
            ref_text_ff <= 32'h00000000;
            ref_det_ff <= 32'h00000000;
            ref_par_ff <= 32'h00000000;
            ref_typ_ff <= 32'h00000000;
        end
        else if (ce)
        begin
            if (job_go) job_num_ff <= int0_ff;
            if (ref_go)
            begin
                ref_len_ff <= nchar;
                ref_text_ff <= text_ff;
                ref_det_ff <= int0_ff;
                ref_par_ff <= int1_ff;
                ref_typ_ff <= int2_ff;
            end
        end
    end

    // results are sampled once per frame so a frame is never torn
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_idx_ff <= 9'h000;
            res_bool_ff <= 8'h00;
            res_text_ff <= 32'h00000000;
            res_int_ff <= 32'h00000000;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= 8'h00;
            rsp_last_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (state_ff == D_EVAL)
            begin
                res_bool_ff <= bool_result;
                res_text_ff <= text_result;
                res_int_ff <= int_result;
            end
            tx_idx_ff <= (state_ff == D_RESP && !tx_at_last) ? 9'(tx_idx_ff + 9'h001) : 9'h000;
            rsp_valid_ff <= (state_ff == D_RESP);
            rsp_data_ff <= (state_ff == D_RESP) ? tx_byte : 8'h00;
            rsp_last_ff <= (state_ff == D_RESP) && tx_at_last;
        end
    end

    assign link.rsp_valid = rsp_valid_ff;
    assign link.rsp_data = rsp_data_ff;
    assign link.rsp_last = rsp_last_ff;
    assign link.sensor_ready = ready_ff;
    assign trig_pulse = trig_ff;
    assign job_pulse = job_ff;
    assign job_number = job_num_ff;
    assign ref_perm_pulse = perm_ff;
    assign ref_temp_pulse = temp_ff;
    assign ref_len = ref_len_ff;
    assign ref_text = ref_text_ff;
    assign ref_detector = ref_det_ff;
    assign ref_param = ref_par_ff;
    assign ref_type = ref_typ_ff;
    assign len_error = len_err_ff;
endmodule
`default_nettype wire

// File: verilog/cad_ctl.sv
// controller end: AXI4-Lite registers, cyclic request frames, result capture
`timescale 1ns/1ps
`default_nettype none
module cad_ctl (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    cad_link_if.ctl link,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import cad_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        return {s[3] ? n[31:24] : o[31:24], s[2] ? n[23:16] : o[23:16],
                s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
    endfunction

    logic aw_free_ff, w_free_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [15:0] code_ff, key_ff;
    logic [31:0] cnt_ff, arg0_ff, arg1_ff, arg2_ff, text_ff;
    logic [7:0] bool_res_ff;
    logic [31:0] int_res_ff, text_res_ff;
    logic pend_ff, linked_ff;
    cad_ctl_state_type state_ff;
    cad_idx_type idx_ff;
    logic req_valid_ff, req_last_ff;
    logic [7:0] req_data_ff;

    wire do_write = !aw_free_ff && !w_free_ff && !bvalid_ff;
    wire wr_map = (awaddr_ff <= REG_TEXTRES) && (awaddr_ff[1:0] == 2'b00);
    wire ar_take = s_axi_arvalid && arready_ff;
    wire [31:0] stat_word = {key_ff, 13'h0000, linked_ff, link.sensor_ready, pend_ff};
    wire rd_map = (s_axi_araddr <= REG_TEXTRES) && (s_axi_araddr[1:0] == 2'b00);
    wire [31:0] rd_word =
        (s_axi_araddr == REG_CMD) ? {16'h0000, code_ff} :
        (s_axi_araddr == REG_CNT) ? cnt_ff :
        (s_axi_araddr == REG_ARG0) ? arg0_ff :
        (s_axi_araddr == REG_ARG1) ? arg1_ff :
        (s_axi_araddr == REG_ARG2) ? arg2_ff :
        (s_axi_araddr == REG_TEXT) ? text_ff :
        (s_axi_araddr == REG_STAT) ? stat_word :
        (s_axi_araddr == REG_BOOL) ? {24'h000000, bool_res_ff} :
        (s_axi_araddr == REG_INTRES) ? int_res_ff :
        (s_axi_araddr == REG_TEXTRES) ? text_res_ff : 32'h00000000;

    // every command waits for ready and goes at the next frame; start itself needs ready
    wire start = (state_ff == H_IDLE) && link.sensor_ready;
    wire launch = start && pend_ff && ((code_ff != CMD_TRIGGER) || link.sensor_ready);
    wire cmd_set = do_write && (awaddr_ff == REG_CMD);
    wire send_end = (state_ff == H_SEND) && (idx_ff == REQ_LAST);
    wire [1:0] lane = idx_ff[1:0];
    // args are read live: software must not rewrite them while the frame that follows the launch is being sent
    wire [7:0] tx_byte =
        word_hit(idx_ff, OFS_KEY) ? lane_byte({code_ff, key_ff}, lane) :
        word_hit(idx_ff, OFS_NCHAR) ? lane_byte(cnt_ff, lane) :
        word_hit(idx_ff, OFS_CHAR) ? lane_byte(text_ff, lane) :
        word_hit(idx_ff, OFS_INT0) ? lane_byte(arg0_ff, lane) :
        word_hit(idx_ff, OFS_INT1) ? lane_byte(arg1_ff, lane) :
        word_hit(idx_ff, OFS_INT2) ? lane_byte(arg2_ff, lane) : 8'h00;
    wire [1:0] rx_lane = idx_ff[1:0];
    wire rx_take = (state_ff == H_WAIT) && link.rsp_valid;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_free_ff <= 1'b1;
            w_free_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && aw_free_ff) awaddr_ff <= s_axi_awaddr;
            if (s_axi_wvalid && w_free_ff) wdata_ff <= s_axi_wdata;
            if (s_axi_wvalid && w_free_ff) wstrb_ff <= s_axi_wstrb;
            aw_free_ff <= do_write || (aw_free_ff && !s_axi_awvalid);
            w_free_ff <= do_write || (w_free_ff && !s_axi_wvalid);
            bvalid_ff <= do_write || (bvalid_ff && !s_axi_bready);
            if (do_write) bresp_ff <= wr_map ? RESP_OKAY : RESP_DECERR;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= RESP_OKAY;
        end
        else if (ce)
        begin
            arready_ff <= (rvalid_ff && s_axi_rready) || (arready_ff && !s_axi_arvalid);
            rvalid_ff <= ar_take || (rvalid_ff && !s_axi_rready);
            if (ar_take) rdata_ff <= rd_word;
            if (ar_take) rresp_ff <= rd_map ? RESP_OKAY : RESP_DECERR;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            code_ff <= 16'h0000;
            cnt_ff <= 32'h00000000;
            arg0_ff <= 32'h00000000;
            arg1_ff <= PARAM_REF_STR;
            arg2_ff <= PTYPE_STR;
            text_ff <= 32'h00000000;
        end
        else if (ce && do_write)
        begin
            if (awaddr_ff == REG_CMD) code_ff <= 16'(merge({16'h0000, code_ff}, wdata_ff, wstrb_ff));
            if (awaddr_ff == REG_CNT) cnt_ff <= merge(cnt_ff, wdata_ff, wstrb_ff);
            if (awaddr_ff == REG_ARG0) arg0_ff <= merge(arg0_ff, wdata_ff, wstrb_ff);
            if (awaddr_ff == REG_ARG1) arg1_ff <= merge(arg1_ff, wdata_ff, wstrb_ff);
            if (awaddr_ff == REG_ARG2) arg2_ff <= merge(arg2_ff, wdata_ff, wstrb_ff);
            if (awaddr_ff == REG_TEXT) text_ff <= merge(text_ff, wdata_ff, wstrb_ff);
        end
    end

    // a new order in the launch cycle stays pending
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pend_ff <= 1'b0;
            key_ff <= KEY_RST;
            linked_ff <= 1'b0;
            state_ff <= H_IDLE;
            idx_ff <= 9'h000;
        end
        else if (ce)
        begin
            pend_ff <= cmd_set || (pend_ff && !launch);
            if (launch) key_ff <= 16'(key_ff + 16'h0001);
            if (start) linked_ff <= 1'b1;
            unique case (state_ff)
                H_IDLE: if (start) state_ff <= H_SEND;
                H_SEND: if (send_end) state_ff <= H_WAIT;
                H_WAIT: if (link.rsp_valid && link.rsp_last) state_ff <= H_IDLE;
                default: state_ff <= H_IDLE;
            endcase
            if (start || send_end || (rx_take && link.rsp_last)) idx_ff <= 9'h000;
            else if (state_ff == H_SEND || rx_take) idx_ff <= 9'(idx_ff + 9'h001);
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_valid_ff <= 1'b0;
            req_data_ff <= 8'h00;
            req_last_ff <= 1'b0;
            bool_res_ff <= 8'h00;
            int_res_ff <= 32'h00000000;
            text_res_ff <= 32'h00000000;
        end
        else if (ce)
        begin
            req_valid_ff <= (state_ff == H_SEND);
            req_data_ff <= (state_ff == H_SEND) ? tx_byte : 8'h00;
            req_last_ff <= send_end;
            if (rx_take && idx_ff == OFS_BOOL) bool_res_ff <= link.rsp_data;
            if (rx_take && word_hit(idx_ff, OFS_INTRES))
                int_res_ff[{rx_lane, 3'b000} +: 8] <= link.rsp_data;
            if (rx_take && word_hit(idx_ff, OFS_TEXT))
                text_res_ff[{rx_lane, 3'b000} +: 8] <= link.rsp_data;
        end
    end

    assign link.req_valid = req_valid_ff;
    assign link.req_data = req_data_ff;
    assign link.req_last = req_last_ff;
    assign s_axi_awready = aw_free_ff;
    assign s_axi_wready = w_free_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
endmodule
`default_nettype wire

// File: sim/cad_link_checker.sv
// concurrent checks on the request and response frames of the link
`timescale 1ns/1ps
`default_nettype none
module cad_link_checker
    import cad_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire logic [7:0] req_data,
    input wire logic req_last,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_last,
    input wire logic sensor_ready
);
    logic [8:0] req_cnt_ff;
    logic [8:0] rsp_cnt_ff;
    logic [7:0] key_lo_ff;
    logic zero_pos;
    // only key, bool, text and integer bytes may carry data
    assign zero_pos = !(rsp_cnt_ff inside {OFS_RSP_KEY, OFS_BOOL, [OFS_TEXT:OFS_TEXT + 9'h003],
        [OFS_INTRES:OFS_INTRES + 9'h003]});
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_cnt_ff <= 9'h000;
            rsp_cnt_ff <= 9'h000;
            key_lo_ff <= 8'h00;
        end
        else
        begin
            if (req_valid)
                req_cnt_ff <= req_last ? 9'h000 : req_cnt_ff + 9'h001;
            if (req_valid && req_cnt_ff == 9'h000)
                key_lo_ff <= req_data;
            if (rsp_valid)
                rsp_cnt_ff <= rsp_last ? 9'h000 : rsp_cnt_ff + 9'h001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_req_len; req_valid |-> (req_last == (req_cnt_ff == REQ_LAST)); endproperty
    a_req_len: assert property (p_req_len) else $error("request length wrong");
    property p_req_run; req_valid && !req_last |=> req_valid; endproperty
    a_req_run: assert property (p_req_run) else $error("request gap");
    property p_rsp_len; rsp_valid |-> (rsp_last == (rsp_cnt_ff == RSP_LAST)); endproperty
    a_rsp_len: assert property (p_rsp_len) else $error("response length wrong");
    property p_rsp_run; rsp_valid && !rsp_last |=> rsp_valid; endproperty
    a_rsp_run: assert property (p_rsp_run) else $error("response gap");
    property p_rsp_soon; req_valid && req_last |-> ##[2:4] rsp_valid; endproperty
    a_rsp_soon: assert property (p_rsp_soon) else $error("no response");
    property p_key_echo; rsp_valid && rsp_cnt_ff == 9'h000 |-> rsp_data == key_lo_ff; endproperty
    a_key_echo: assert property (p_key_echo) else $error("key not mirrored");
    property p_rsp_zero; rsp_valid && zero_pos |-> rsp_data == 8'h00; endproperty
    a_rsp_zero: assert property (p_rsp_zero) else $error("stray response byte");
    property p_no_overlap; rsp_valid |-> !req_valid; endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("request during response");
    // the frame start was decided two edges before its first byte is seen
    property p_ready; $rose(req_valid) |-> $past(sensor_ready, 2); endproperty
    a_ready: assert property (p_ready) else $error("frame while not ready");
endmodule
`default_nettype wire

// File: sim/tb.sv
// self-checking bench for controller and sensor ends joined by the link
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cad_pkg::*;
    logic clk, arst_n, ce, sensor_ready, trig_pulse, job_pulse, len_error, clr_seen;
    logic ref_perm_pulse, ref_temp_pulse, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [7:0] bool_result, s_axi_awaddr, s_axi_araddr;
    logic [31:0] text_result, int_result, job_number, ref_text, ref_detector, ref_param;
    logic [31:0] ref_type, s_axi_wdata, s_axi_rdata, rd;
    logic [15:0] ref_len, exp_key;
    logic [3:0] s_axi_wstrb;
    logic [4:0] seen;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_fail, n_tests;
    typedef struct {logic [15:0] cmd; logic [31:0] cnt, arg, txt; logic [3:0] mask;} cad_row_type;
    // mask bits: temp, perm, job, trigger
    cad_row_type rows [7] = '{'{CMD_TRIGGER, 0, 0, 0, 4'h1},
        '{CMD_JOB, 32'h00010000, 32'h7, 0, 4'h2},
        '{CMD_REF_PERM, 32'h00030001, 32'h1, 32'h43, 4'h4},
        '{CMD_REF_TEMP, 32'h00030002, 32'h1, 32'h4241, 4'h8},
        '{16'h0004, 0, 0, 0, 4'h0},
        '{CMD_JOB, 0, 32'h9, 0, 4'h0},
        '{CMD_REF_TEMP, 32'h00020002, 32'h2, 32'h4241, 4'h0}};
    cad_link_if link();
    cad_dev u_cad_dev (.*);
    cad_ctl u_cad_ctl (.*);
    cad_link_checker u_cad_link_checker (.clk(clk), .arst_n(arst_n),
        .req_valid(link.req_valid), .req_data(link.req_data), .req_last(link.req_last),
        .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data), .rsp_last(link.rsp_last),
        .sensor_ready(link.sensor_ready));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // bit 4 is a length error, which no clean frame may raise
    always @(posedge clk)
        seen <= clr_seen ? 5'h00 :
            seen | {len_error, ref_temp_pulse, ref_perm_pulse, job_pulse, trig_pulse};
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
    endtask
    // whole response frames, so nothing depends on the link latency
    task automatic frames(input int n);
        repeat (n)
        begin
            @(posedge clk);
            while (!link.rsp_last) @(posedge clk);
        end
    endtask
    task automatic complete_run;
        if (n_fail == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        {ce, sensor_ready, arst_n, s_axi_bready, s_axi_rready} = 5'b11011;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, s_axi_wstrb, clr_seen, exp_key, n_fail, n_tests} = {32'h0, 4'hf, 17'h0, 64'h0};
        {bool_result, text_result, int_result} = {8'ha5, 32'h44434241, 32'h12345678};
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd_reg(REG_ARG1);
        chk(rd, PARAM_REF_STR);
        for (int i = 0; i < 7; i++)
        begin
            wr(REG_CNT, rows[i].cnt);
            wr(REG_ARG0, rows[i].arg);
            wr(REG_TEXT, rows[i].txt);
            clr_seen <= 1'b1;
            @(posedge clk);
            clr_seen <= 1'b0;
            wr(REG_CMD, {16'h0000, rows[i].cmd});
            frames(3);
            exp_key = exp_key + 16'h0001;
            chk(seen, rows[i].mask);
            rd_reg(REG_STAT);
            chk(rd[31:16], exp_key);
            if (rows[i].mask[1]) chk(job_number, rows[i].arg);
            if (rows[i].mask[3:2] != 2'b00)
            begin
                chk(ref_len, rows[i].cnt[15:0]);
                chk(ref_text, rows[i].txt);
                chk(ref_detector, rows[i].arg);
                chk(ref_param, PARAM_REF_STR);
                chk(ref_type, PTYPE_STR);
            end
        end
        clr_seen <= 1'b1;
        @(posedge clk);
        clr_seen <= 1'b0;
        frames(2);
        chk(seen, 4'h0);
        rd_reg(REG_BOOL);
        chk(rd[7:0], bool_result);
        rd_reg(REG_TEXTRES);
        chk(rd, text_result);
        rd_reg(REG_INTRES);
        chk(rd, int_result);
        rd_reg(8'h28);
        chk(s_axi_rresp, RESP_DECERR);
        // trigger stays pending while the sensor is not ready
        sensor_ready <= 1'b0;
        wr(REG_CMD, {16'h0000, CMD_TRIGGER});
        repeat (2000) @(posedge clk);
        rd_reg(REG_STAT);
        chk(rd, {exp_key, 16'h0005});
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd_reg(REG_STAT);
        chk(rd, {KEY_RST, 16'h0000});
        complete_run();
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        n_fail++;
        complete_run();
    end
endmodule
`default_nettype wire
